/* File: core/sps_pkg.sv */
// constants and types shared by the stepper phase sequencer
package sps_pkg;

  localparam int unsigned SPS_CLK_MHZ = 200;

  // host-side timing, kept so that benches and checks share the figures
  localparam int unsigned SPS_DIR_SETUP_NS = 6250;
  localparam int unsigned SPS_MODE_SETUP_NS = 5000;
  localparam int unsigned SPS_RST_TO_STEP_NS = 10000;
  localparam int unsigned SPS_RST_TO_STEP_CYC =
    (SPS_RST_TO_STEP_NS * SPS_CLK_MHZ + 999) / 1000;

  // position register: three bits, eight half steps per electrical turn
  localparam int unsigned SPS_POS_W = 3;
  localparam logic [2:0] SPS_POS_RST = 3'h0;
  localparam logic [2:0] SPS_POS_STEP_HALF = 3'h1;
  localparam logic [2:0] SPS_POS_STEP_FULL = 3'h2;

  // register map over AHB-Lite
  localparam logic [11:0] SPS_ADDR_CTRL = 12'h000;
  localparam logic [11:0] SPS_ADDR_STAT = 12'h004;
  localparam logic [11:0] SPS_ADDR_IRQ_STAT = 12'h008;
  localparam logic [11:0] SPS_ADDR_IRQ_MASK = 12'h00C;

  // status bits
  localparam int unsigned SPS_BIT_POS = 0;
  localparam int unsigned SPS_BIT_FAULT = 4;
  // irq bits
  localparam int unsigned SPS_IRQ_STEP = 0;
  localparam int unsigned SPS_IRQ_FAULT = 1;
  localparam logic [1:0] SPS_IRQ_MASK_RST = 2'h0;

  typedef struct packed {
    logic phase_one;
    logic phase_one_complement;
    logic phase_two;
    logic phase_two_complement;
  } sps_phase_t;

  localparam sps_phase_t SPS_PHASE_OFF = 4'h0;

  typedef struct packed {
    logic excitation_select;
    logic edge_select;
    logic direction_select;
    logic enable;
  } sps_ctrl_t;

endpackage : sps_pkg

/* File: core/sps_sync.sv */
// two-flop synchroniser for asynchronous pin inputs
module sps_sync
  import sps_pkg::*;
#(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      q <= '0;
    end else if (clk_en) begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : sps_sync

/* File: core/sps_core.sv */
// stepper phase sequencer: step clock sampling, position, faults, ahb regs
module sps_core
  import sps_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // motor pins
  input wire logic step_clock,
  input wire logic excitation_select,
  input wire logic edge_select,
  input wire logic direction_select,
  input wire logic system_reset_low,
  input wire logic enable,
  input wire logic overcurrent_det,
  input wire logic overheat_det,
  output sps_phase_t phase_out,
  output logic fault_n,
  output logic irq
);

  // all pins cross into hclk through two flops
  logic [7:0] pin_s;
  sps_sync #(.W(8)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .d({step_clock, excitation_select, edge_select, direction_select,
        system_reset_low, enable, overcurrent_det, overheat_det}),
    .q(pin_s)
  );

  wire step_s = pin_s[7];
  wire exc_s = pin_s[6];
  wire edge_s = pin_s[5];
  wire dir_s = pin_s[4];
  wire srst_n_s = pin_s[3];
  wire en_s = pin_s[2];
  wire oc_s = pin_s[1];
  wire oh_s = pin_s[0];

  logic step_prev_q;
  logic [2:0] pos_q, pos_d;
  logic fault_q;
  logic [1:0] irq_stat_q, irq_stat_d;
  logic [1:0] irq_mask_q;
  logic [31:0] hrdata_q;
  logic dph_rd_q, dph_wr_q;
  logic [11:0] dph_addr_q;

  // edge detect on the synchronised step clock
  wire rise = step_s & ~step_prev_q;
  wire fall = ~step_s & step_prev_q;
  // static clock gives no edge, so position holds
  wire step_go = rise | (fall & ~edge_s);

  // full step lives on odd positions so the reset point is one of them;
  // entering full step from an even half step rounds in the step direction
  wire [2:0] inc = exc_s ? SPS_POS_STEP_HALF : SPS_POS_STEP_FULL;
  wire aligned = exc_s | pos_q[0];
  wire [2:0] fwd = aligned ? 3'(pos_q + inc) : 3'(pos_q + SPS_POS_STEP_HALF);
  wire [2:0] rev = aligned ? 3'(pos_q - inc) : 3'(pos_q - SPS_POS_STEP_HALF);

  always_comb begin
    pos_d = pos_q;
    if (step_go) begin
      pos_d = dir_s ? rev : fwd;
    end
  end

  // reset pin low forces position one and clears the fault; release starts from position one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_prev_q <= 1'b0;
      pos_q <= 3'h1;
    end else if (clk_en) begin
      step_prev_q <= step_s;
      if (!srst_n_s) begin
        pos_q <= 3'h1;
      end else begin
        pos_q <= pos_d;
      end
    end
  end

  // latched fault, cleared only by the reset pin or hresetn
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_q <= 1'b0;
    end else if (clk_en) begin
      if (!srst_n_s) begin
        fault_q <= 1'b0;
      end else if (oc_s | oh_s) begin
        fault_q <= 1'b1;
      end
    end
  end

  // phase decode: position 1 is phase one with phase two complement
  sps_phase_t dec;
  always_comb begin
    case (pos_q)
      3'h0: dec = 4'b1000;
      3'h1: dec = 4'b1001;
      3'h2: dec = 4'b0001;
      3'h3: dec = 4'b0101;
      3'h4: dec = 4'b0100;
      3'h5: dec = 4'b0110;
      3'h6: dec = 4'b0010;
      3'h7: dec = 4'b1010;
      default: dec = SPS_PHASE_OFF;
    endcase
  end

  wire drive_ok = en_s & srst_n_s & ~fault_q;

  sps_phase_t phase_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= SPS_PHASE_OFF;
    end else if (clk_en) begin
      // position keeps counting under enable low, outputs just go dark
      phase_q <= drive_ok ? dec : SPS_PHASE_OFF;
    end
  end
  assign phase_out = phase_q;
  assign fault_n = ~fault_q;

  // ahb-lite: zero wait states, always okay
  wire addr_ok = hsel & hready & htrans[1];
  wire rd_stat = dph_rd_q & (dph_addr_q == SPS_ADDR_IRQ_STAT);
  wire wr_ctrl_mask = dph_wr_q & (dph_addr_q == SPS_ADDR_IRQ_MASK);
  wire [1:0] events = {fault_q & ~irq_stat_q[SPS_IRQ_FAULT] & (oc_s | oh_s),
                       step_go & srst_n_s};
  // set wins over the read clear
  assign irq_stat_d = (rd_stat ? 2'h0 : irq_stat_q) | events;

  wire [31:0] rd_mux =
    (haddr == SPS_ADDR_STAT) ? {27'h0, fault_q, 1'b0, pos_q} :
    (haddr == SPS_ADDR_CTRL) ? {28'h0, exc_s, edge_s, dir_s, en_s} :
    (haddr == SPS_ADDR_IRQ_STAT) ? {30'h0, irq_stat_q} :
    (haddr == SPS_ADDR_IRQ_MASK) ? {30'h0, irq_mask_q} : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_rd_q <= 1'b0;
      dph_wr_q <= 1'b0;
      dph_addr_q <= 12'h000;
      hrdata_q <= 32'h0;
      irq_stat_q <= 2'h0;
      irq_mask_q <= SPS_IRQ_MASK_RST;
    end else if (clk_en) begin
      dph_rd_q <= addr_ok & ~hwrite;
      dph_wr_q <= addr_ok & hwrite;
      dph_addr_q <= haddr;
      if (addr_ok & ~hwrite) begin
        hrdata_q <= rd_mux;
      end
      irq_stat_q <= irq_stat_d;
      if (wr_ctrl_mask) begin
        irq_mask_q <= hwdata[1:0];
      end
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(irq_stat_q & irq_mask_q);

  // checks
  a_fault_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && fault_q && srst_n_s |=> fault_q)
    else $error("fault latch dropped without reset");
  a_fault_pin: assert property (@(posedge hclk) disable iff (!hresetn)
    fault_n == !fault_q)
    else $error("fault pin does not follow latch");
  a_off_disable: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && !en_s |=> phase_out == SPS_PHASE_OFF)
    else $error("phases driven while disabled");
  a_hold_static: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && srst_n_s && !rise && !fall |=> $stable(pos_q))
    else $error("position moved without step edge");
  a_rise_only: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && srst_n_s && edge_s && fall |=> $stable(pos_q))
    else $error("falling edge stepped in rising mode");
  a_both_edges: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && srst_n_s && !edge_s && fall |=> !$stable(pos_q))
    else $error("falling edge missed in dual edge mode");
  a_half_fwd: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && srst_n_s && rise && exc_s && !dir_s
    |=> pos_q == 3'($past(pos_q) + 3'h1))
    else $error("half step forward wrong");
  a_full_rev: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && srst_n_s && rise && !exc_s && dir_s && pos_q[0]
    |=> pos_q == 3'($past(pos_q) - 3'h2))
    else $error("full step reverse wrong");
  a_reset_init: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && !srst_n_s |=> pos_q == 3'h1)
    else $error("reset position wrong");
  a_resume_pos: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && $fell(en_s) && srst_n_s ##1 (!step_go && clk_en)
    |=> $stable(pos_q))
    else $error("position lost on disable");
  c_half_step: cover property (@(posedge hclk) exc_s && step_go);
  c_full_step: cover property (@(posedge hclk) !exc_s && step_go);
  c_fault: cover property (@(posedge hclk) $rose(fault_q));
  c_irq: cover property (@(posedge hclk) $rose(irq));

endmodule : sps_core

/* File: sim/sps_host.sv */
// host step-pulse controller model: step clock and system reset pins
module sps_host
  import sps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic step_clock = 1'b0;
  logic system_reset_low = 1'b0;
  // 64 ns step clock, still and low between bursts; async to hclk
  task automatic edges(input int n);
    repeat (n) begin
      #32;
      step_clock = ~step_clock;
    end
    #40;
  endtask : edges
  // high-low-high pulse, then settle before any step edge
  task automatic reset_pulse();
    system_reset_low = 1'b0;
    #100;
    system_reset_low = 1'b1;
    #(SPS_RST_TO_STEP_NS);
  endtask : reset_pulse
endmodule : sps_host

/* File: sim/stepper_phase_sequencer_test.sv */
// self-checking bench for the stepper phase sequencer
module stepper_phase_sequencer_test
  import sps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic clk_en = 1'b1;
  // hold time around a rising step edge, in hclk cycles
  localparam int unsigned HOLD_CYC = SPS_DIR_SETUP_NS * SPS_CLK_MHZ / 1000;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic exc = 1'b0;
  logic edg = 1'b1;
  logic dir = 1'b0;
  logic enable = 1'b1;
  logic ocd = 1'b0;
  logic ohd = 1'b0;
  sps_phase_t phase_out;
  logic fault_n;
  logic irq;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;

  sps_host host ();
  sps_core dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .step_clock(host.step_clock),
    .excitation_select(exc), .edge_select(edg), .direction_select(dir),
    .system_reset_low(host.system_reset_low), .enable(enable),
    .overcurrent_det(ocd), .overheat_det(ohd), .phase_out(phase_out),
    .fault_n(fault_n), .irq(irq));

  always #2.5 hclk = ~hclk;

  // cut a hang short
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 50000) begin
      failures++;
      results();
    end
  end

  task automatic results();
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    xfer(1'b0, a, 32'h0, d);
    chk(d, exp);
  endtask : rd

  // modes change only while the step clock is idle, with the host's
  // hold and setup margins kept around the neighbouring rising edges
  task automatic mode(input logic e, input logic g, input logic r);
    repeat (HOLD_CYC) @(posedge hclk);
    exc <= e;
    edg <= g;
    dir <= r;
    repeat (HOLD_CYC) @(posedge hclk);
  endtask : mode

  task automatic t_reset();
    host.reset_pulse();
    chk({28'h0, phase_out}, 32'h9);
    chk({31'h0, fault_n}, 32'h1);
    rd(SPS_ADDR_STAT, 32'h1);
    rd(SPS_ADDR_CTRL, 32'h5);
    rd(12'h010, 32'h0);
    chk({31'h0, hresp}, 32'h0);
  endtask : t_reset

  task automatic t_steps();
    mode(1'b0, 1'b1, 1'b0);
    host.edges(2);
    rd(SPS_ADDR_STAT, 32'h3);
    host.edges(6);
    rd(SPS_ADDR_STAT, 32'h1);
    mode(1'b1, 1'b0, 1'b0);
    host.edges(2);
    rd(SPS_ADDR_STAT, 32'h3);
    mode(1'b1, 1'b0, 1'b1);
    host.edges(4);
    rd(SPS_ADDR_STAT, 32'h7);
    mode(1'b0, 1'b1, 1'b0);
    host.edges(2);
    rd(SPS_ADDR_STAT, 32'h1);
    chk({28'h0, phase_out}, 32'h9);
  endtask : t_steps

  task automatic t_enable();
    sps_phase_t p;
    @(posedge hclk);
    enable <= 1'b0;
    repeat (8) @(posedge hclk);
    chk({28'h0, phase_out}, 32'h0);
    host.edges(2);
    rd(SPS_ADDR_STAT, 32'h3);
    host.edges(6);
    @(posedge hclk);
    enable <= 1'b1;
    repeat (8) @(posedge hclk);
    chk({28'h0, phase_out}, 32'h9);
    p = phase_out;
    repeat (200) @(posedge hclk);
    chk({28'h0, phase_out}, {28'h0, p});
    // frozen clock enable: step edges pass unseen, position holds
    @(posedge hclk);
    clk_en <= 1'b0;
    host.edges(2);
    @(posedge hclk);
    clk_en <= 1'b1;
    repeat (8) @(posedge hclk);
    rd(SPS_ADDR_STAT, 32'h1);
  endtask : t_enable

  task automatic t_fault();
    logic [31:0] d;
    xfer(1'b1, SPS_ADDR_IRQ_MASK, 32'h3, d);
    xfer(1'b0, SPS_ADDR_IRQ_STAT, 32'h0, d);
    host.edges(2);
    chk({31'h0, irq}, 32'h1);
    rd(SPS_ADDR_IRQ_STAT, 32'h1);
    // the read clear lands at the data phase edge; look once it settles
    @(negedge hclk);
    chk({31'h0, irq}, 32'h0);
    @(posedge hclk);
    ocd <= 1'b1;
    repeat (8) @(posedge hclk);
    ocd <= 1'b0;
    repeat (8) @(posedge hclk);
    chk({31'h0, fault_n}, 32'h0);
    chk({28'h0, phase_out}, 32'h0);
    rd(SPS_ADDR_STAT, 32'h13);
    rd(SPS_ADDR_IRQ_STAT, 32'h2);
    host.reset_pulse();
    chk({31'h0, fault_n}, 32'h1);
    chk({28'h0, phase_out}, 32'h9);
    @(posedge hclk);
    ohd <= 1'b1;
    repeat (8) @(posedge hclk);
    ohd <= 1'b0;
    repeat (8) @(posedge hclk);
    chk({31'h0, fault_n}, 32'h0);
    rd(SPS_ADDR_IRQ_STAT, 32'h2);
    xfer(1'b1, SPS_ADDR_IRQ_MASK, 32'h0, d);
    host.reset_pulse();
    host.edges(2);
    chk({31'h0, irq}, 32'h0);
    rd(SPS_ADDR_IRQ_STAT, 32'h1);
  endtask : t_fault

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_steps();
    t_enable();
    t_fault();
    results();
  end
endmodule : stepper_phase_sequencer_test
